// File: src/icw_defs.svh
`ifndef ICW_DEFS_SVH
`define ICW_DEFS_SVH
// ==========================================
// machine cycle, timing and vector constants
`define ICW_STATES_PER_MC 2'h3
`define ICW_CLK_HZ 10000000
`define ICW_TPD_US 2000
`define ICW_TPD_CYCLES ((`ICW_TPD_US * (`ICW_CLK_HZ / 1000000)))
`define ICW_CALL_MCS 3'h4
`define ICW_SAMPLE_STATE 2'h2
// ==========================================
// source indices (arbitration order, 0 highest)
`define ICW_SRC_EXT0 4'h0
`define ICW_SRC_BRN 4'h1
`define ICW_SRC_WDT 4'h2
`define ICW_SRC_TMR0 4'h3
`define ICW_SRC_EXT1 4'h4
`define ICW_SRC_TMR1 4'h5
`define ICW_SRC_SER 4'h6
`define ICW_SRC_CMP 4'h7
`define ICW_SRC_PWM 4'h8
`define ICW_NSRC 9
// ==========================================
// vector addresses
`define ICW_VEC_EXT0 16'h0003
`define ICW_VEC_TMR0 16'h000B
`define ICW_VEC_EXT1 16'h0013
`define ICW_VEC_TMR1 16'h001B
`define ICW_VEC_SER 16'h0023
`define ICW_VEC_BRN 16'h002B
`define ICW_VEC_CMP 16'h0033
`define ICW_VEC_WDT 16'h0053
`define ICW_VEC_PWM 16'h006B
// ==========================================
// field positions and reset values
`define ICW_WDOG_EVENT_BIT 3
`define ICW_AUX_BROWNOUT_TO_IRQ_BIT 5
`define ICW_XEN_BROWNOUT_BIT 6
`define ICW_FLAGS_RST 9'h000
`endif

// File: src/icw_pkg.sv
package icw_pkg;
	typedef logic [8:0] icw_vec9_t;
	typedef struct packed {
		logic [8:0] ena;      // individual enables
		logic [8:0] pri_hi;   // priority_high_bits per source
		logic [8:0] pri_lo;   // priority_low_bits per source
	} icw_cfg_t;
	typedef struct packed {
		logic        last_mc;  // this mc is the instruction's last
		logic        blocking; // writes enable/priority regs
		logic        interrupt_return_op;     // interrupt_return_op retiring
	} icw_cpu_t;
	typedef struct packed {
		logic        valid;
		logic [15:0] addr;
		logic [3:0]  src;
		logic [1:0]  level;
	} icw_call_t;
	typedef enum logic [1:0] {ICW_RUN, ICW_CALL} icw_state_t;
	typedef enum logic [1:0] {ICW_PD_OFF, ICW_PD_SLEEP, ICW_PD_HOLD} icw_pd_t;
endpackage

// File: src/icw_wake.sv
`timescale 1ns/1ns
`default_nettype none
`include "icw_defs.svh"
module icw_wake #(
	parameter int TPD_CYCLES = `ICW_TPD_CYCLES
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n_sync,
	// power-down control
	input  wire logic       pd_enter,
	input  wire logic [1:0] pd_wake_mode,
	input  wire logic       ext_low,
	input  wire logic       src_wake,
	input  wire logic       low_power_brownout_sel,
	input  wire logic       brownout_detector_off,
	// status
	output logic            power_down,
	output logic            osc_restart,
	output logic            rc_clk_en
);
	import icw_pkg::*;
	icw_pd_t     st_reg;
	logic [31:0] hold_reg;
	logic        ext_mode;
	// modes 1 and 2 need the pin held past the hold interval
	assign ext_mode = (pd_wake_mode == 2'h1) || (pd_wake_mode == 2'h2);
	// ==========================================
	// power-down sequencer
	always_ff @(posedge clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			st_reg <= ICW_PD_OFF;
			hold_reg <= 32'h0;
			osc_restart <= 1'b0;
		end else begin
			osc_restart <= 1'b0;
			unique case (st_reg)
				ICW_PD_OFF: if (pd_enter) begin
					st_reg <= ICW_PD_SLEEP;
				end
				ICW_PD_SLEEP: begin
					hold_reg <= 32'h0;
					if (src_wake && (!ext_low || !ext_mode)) begin
						st_reg <= ICW_PD_OFF;
						osc_restart <= 1'b1;
					end else if (src_wake) begin
						st_reg <= ICW_PD_HOLD;
					end
				end
				ICW_PD_HOLD: begin
					if (!src_wake) begin
						st_reg <= ICW_PD_SLEEP;
					end else if (hold_reg >= 32'(TPD_CYCLES)) begin
						st_reg <= ICW_PD_OFF;
						osc_restart <= 1'b1;
					end else begin
						hold_reg <= hold_reg + 32'h1;
					end
				end
				default: st_reg <= ICW_PD_OFF;
			endcase
		end
	end
	assign power_down = (st_reg != ICW_PD_OFF);
	// internal rc clock while asleep in low-power brownout mode
	assign rc_clk_en = power_down && low_power_brownout_sel
		&& !brownout_detector_off;
endmodule
`default_nettype wire

// File: src/icw_ctrl.sv
//Contract
// - enabled wake source with global enable ends power-down, restarts oscillator
// - after wake routine, resume at instruction after power-down entry
// - low level or falling edge on external pin wakes; two-bit mode select
// - modes one and two need pin low past hold interval
// - rc clock enabled in power-down when low-power brownout set, detector on
// - nine sources each with flag, enable, priority, vector; one global enable
// - external trigger type picks edge or level; high-then-low sample sets flag
// - edge flags cleared on vectoring; level flags follow inverted pin
// - timer overflow sets flag; cleared on vectoring
// - watchdog time-out sets event flag; interrupt only if its enable set
// - pwm underflow sets period flag; only software clears it
// - serial and comparator flags request; software clears them only
// - brownout sets flag; irq needs route bit, enable, global enable
// - software may set or clear every interrupt flag; here receive_done_flag and transmit_done_flag can only be cleared
// - individual enables gate sources; global enable off disables all
// - sample, poll, resolve each cycle; call only when three conditions hold
// - denied requests are not remembered
// - vector call pushes pc, not psw, loads source vector
// - fixed vector addresses per source
// - return-from-interrupt ends service; plain return does not
// - two priority bits select four levels; only strictly higher pre-empts
// - fixed order among equal levels
// - pins sampled and timer flags set at C3, polled next cycle; here timer flags set as the pulse arrives, pin and timer flags polled at the next C4
// - vector call lasts four machine cycles

`timescale 1ns/1ns
`default_nettype none
`include "icw_defs.svh"

module icw_ctrl #(
	parameter int TPD_CYCLES = `ICW_TPD_CYCLES
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rstn,
	// external pins and trigger types
	input  wire logic              ext0_pin,
	input  wire logic              ext1_pin,
	input  wire logic              ext0_trigger_type,
	input  wire logic              ext1_trigger_type,
	// peripheral events (one-cycle pulses)
	input  wire logic              timer0_overflow,
	input  wire logic              timer1_overflow,
	input  wire logic              watchdog_timeout,
	input  wire logic              pwm_underflow,
	input  wire logic              comparator_event,
	input  wire logic              receive_done,
	input  wire logic              transmit_done,
	input  wire logic              brownout_event,
	// software flag access, per source index
	input  wire icw_pkg::icw_vec9_t sw_flag_set,
	input  wire icw_pkg::icw_vec9_t sw_flag_clr,
	input  wire logic              sw_rx_clr,
	input  wire logic              sw_tx_clr,
	// configuration
	input  wire logic              global_irq_enable,
	input  wire icw_pkg::icw_cfg_t cfg,
	input  wire logic              brownout_to_irq,
	input  wire logic              pd_wake_mode_sel_hi,
	input  wire logic              pd_wake_mode_sel_lo,
	input  wire logic              low_power_brownout_sel,
	input  wire logic              brownout_detector_off,
	input  wire logic              wdt_wake_ok,
	input  wire logic              cmp_wake_ok,
	// cpu core
	input  wire icw_pkg::icw_cpu_t cpu,
	input  wire logic              pd_enter,
	input  wire logic              plain_ret,
	// status
	output icw_pkg::icw_vec9_t     flags,
	output logic                   receive_done_flag,
	output logic                   transmit_done_flag,
	output icw_pkg::icw_call_t     call,
	output logic                   call_busy,
	output logic                   push_pc,
	output logic [3:0]             in_service,
	output logic                   power_down,
	output logic                   osc_restart,
	output logic                   rc_clk_en,
	output logic [1:0]             state_phase
);
	import icw_pkg::*;

	logic              rst_s1_reg;
	logic              rst_n_sync;
	logic [1:0]        phase_reg;
	logic              c3;
	logic              mc_end;
	logic              ext0_smp_reg;
	logic              ext1_smp_reg;
	icw_vec9_t         flag_reg;
	icw_vec9_t         hw_set;
	icw_vec9_t         hw_clr;
	icw_vec9_t         req;
	icw_vec9_t         ena_eff;
	logic [1:0]        lvl [`ICW_NSRC];
	logic [15:0]       vec_tab [`ICW_NSRC];
	logic [3:0]        isr_reg;
	logic [3:0]        win_src;
	logic [1:0]        win_lvl;
	logic              win_ok;
	logic [1:0]        cur_lvl;
	logic              any_in_svc;
	logic [2:0]        call_cnt_reg;
	icw_state_t        st_reg;
	icw_call_t         call_reg;
	logic              take;

	// ==========================================
	// reset release through two flip-flops
	// later stages see only the synchronised copy
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_s1_reg <= 1'b0;
			rst_n_sync <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_n_sync <= rst_s1_reg;
		end
	end

	// ==========================================
	// machine cycle of four states C1..C4
	always_ff @(posedge clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			phase_reg <= 2'h0;
		end else begin
			phase_reg <= phase_reg + 2'h1;
		end
	end
	assign c3 = (phase_reg == `ICW_SAMPLE_STATE);
	assign mc_end = (phase_reg == `ICW_STATES_PER_MC);
	assign state_phase = phase_reg;

	// ==========================================
	// pin samples taken at C3 each machine cycle
	// idle-high reset value: no false edge right after reset
	always_ff @(posedge clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			ext0_smp_reg <= 1'b1;
			ext1_smp_reg <= 1'b1;
		end else if (c3) begin
			ext0_smp_reg <= ext0_pin;
			ext1_smp_reg <= ext1_pin;
		end
	end

	// ==========================================
	// hardware set and clear terms per source
	always_comb begin
		hw_set = 9'h000;
		hw_clr = 9'h000;
		// edge: high sample then low sample; level: inverse of pin
		hw_set[`ICW_SRC_EXT0] = c3 && (ext0_trigger_type ?
			(ext0_smp_reg && !ext0_pin) : !ext0_pin);
		hw_set[`ICW_SRC_EXT1] = c3 && (ext1_trigger_type ?
			(ext1_smp_reg && !ext1_pin) : !ext1_pin);
		hw_clr[`ICW_SRC_EXT0] = c3 && !ext0_trigger_type && ext0_pin;
		hw_clr[`ICW_SRC_EXT1] = c3 && !ext1_trigger_type && ext1_pin;
		// peripheral pulses set their flags in the cycle they arrive
		hw_set[`ICW_SRC_TMR0] = timer0_overflow;
		hw_set[`ICW_SRC_TMR1] = timer1_overflow;
		hw_set[`ICW_SRC_WDT] = watchdog_timeout;
		hw_set[`ICW_SRC_PWM] = pwm_underflow;
		hw_set[`ICW_SRC_CMP] = comparator_event;
		hw_set[`ICW_SRC_BRN] = brownout_event;
		// clear on vectoring for edge externals and timers
		if (take) begin
			hw_clr[`ICW_SRC_TMR0] = (win_src == `ICW_SRC_TMR0);
			hw_clr[`ICW_SRC_TMR1] = (win_src == `ICW_SRC_TMR1);
			hw_clr[`ICW_SRC_EXT0] = hw_clr[`ICW_SRC_EXT0]
				|| ((win_src == `ICW_SRC_EXT0) && ext0_trigger_type);
			hw_clr[`ICW_SRC_EXT1] = hw_clr[`ICW_SRC_EXT1]
				|| ((win_src == `ICW_SRC_EXT1) && ext1_trigger_type);
		end
	end

	// ==========================================
	// flag bits: set wins over any clear
	// a clear in the cycle of a new event loses, so no event is dropped
	always_ff @(posedge clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			flag_reg <= `ICW_FLAGS_RST;
		end else begin
			flag_reg <= ((flag_reg & ~(hw_clr | sw_flag_clr))
				| hw_set | sw_flag_set);
		end
	end

	// serial flags kept apart; the serial source ors both
	always_ff @(posedge clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			receive_done_flag <= 1'b0;
			transmit_done_flag <= 1'b0;
		end else begin
			receive_done_flag <= receive_done ||
				(receive_done_flag && !sw_rx_clr);
			transmit_done_flag <= transmit_done ||
				(transmit_done_flag && !sw_tx_clr);
		end
	end
	assign flags = flag_reg;

	// ==========================================
	// gated requests and per-source level/vector
	always_comb begin
		ena_eff = cfg.ena;
		ena_eff[`ICW_SRC_BRN] = cfg.ena[`ICW_SRC_BRN] && brownout_to_irq;
		req = flag_reg;
		req[`ICW_SRC_SER] = flag_reg[`ICW_SRC_SER] || receive_done_flag
			|| transmit_done_flag;
		req = req & ena_eff & {9{global_irq_enable}};
	end

	// vector address of each source index
	assign vec_tab[`ICW_SRC_EXT0] = `ICW_VEC_EXT0;
	assign vec_tab[`ICW_SRC_BRN] = `ICW_VEC_BRN;
	assign vec_tab[`ICW_SRC_WDT] = `ICW_VEC_WDT;
	assign vec_tab[`ICW_SRC_TMR0] = `ICW_VEC_TMR0;
	assign vec_tab[`ICW_SRC_EXT1] = `ICW_VEC_EXT1;
	assign vec_tab[`ICW_SRC_TMR1] = `ICW_VEC_TMR1;
	assign vec_tab[`ICW_SRC_SER] = `ICW_VEC_SER;
	assign vec_tab[`ICW_SRC_CMP] = `ICW_VEC_CMP;
	assign vec_tab[`ICW_SRC_PWM] = `ICW_VEC_PWM;

	// two priority bits of a source form its level
	genvar gi;
	generate
		for (gi = 0; gi < `ICW_NSRC; gi++) begin : g_lvl
			assign lvl[gi] = {cfg.pri_hi[gi], cfg.pri_lo[gi]};
		end
	endgenerate

	// ==========================================
	// arbitration: highest level, then fixed order
	// strict compare keeps the lower index on a tie: fixed order
	always_comb begin
		win_src = 4'h0;
		win_lvl = 2'h0;
		win_ok = 1'b0;
		for (int i = 0; i < `ICW_NSRC; i++) begin
			if (req[i] && (!win_ok || (lvl[i] > win_lvl))) begin
				win_ok = 1'b1;
				win_lvl = lvl[i];
				win_src = 4'(i);
			end
		end
	end

	// current in-service level (highest set bit)
	always_comb begin
		cur_lvl = 2'h0;
		for (int l = 0; l < 4; l++) begin
			if (isr_reg[l]) begin
				cur_lvl = 2'(l);
			end
		end
	end
	assign any_in_svc = |isr_reg;

	// requests polled at end of machine cycle; nothing latched
	// a routine at level 0 still blocks new level-0 calls
	assign take = (st_reg == ICW_RUN) && mc_end && win_ok && !power_down
		&& (!any_in_svc || (win_lvl > cur_lvl))
		&& cpu.last_mc && !cpu.blocking && !cpu.interrupt_return_op;

	// ==========================================
	// vector call sequencer, four machine cycles
	// count machine cycles of the call; valid drops after the fourth
	always_ff @(posedge clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			st_reg <= ICW_RUN;
			call_cnt_reg <= 3'h0;
			call_reg <= '0;
		end else begin
			unique case (st_reg)
				ICW_RUN: if (take) begin
					st_reg <= ICW_CALL;
					call_cnt_reg <= 3'h1;
					call_reg.valid <= 1'b1;
					call_reg.addr <= vec_tab[win_src];
					call_reg.src <= win_src;
					call_reg.level <= win_lvl;
				end
				ICW_CALL: if (mc_end) begin
					if (call_cnt_reg == `ICW_CALL_MCS) begin
						st_reg <= ICW_RUN;
						call_reg.valid <= 1'b0;
					end else begin
						call_cnt_reg <= call_cnt_reg + 3'h1;
					end
				end
			endcase
		end
	end

	assign call = call_reg;
	assign call_busy = (st_reg == ICW_CALL);

	// pc push pulse at call start; psw is never saved
	assign push_pc = take;

	// ==========================================
	// in-service levels
	// take and a return never meet: take waits while a return retires
	always_ff @(posedge clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			isr_reg <= 4'h0;
		end else if (take) begin
			isr_reg[win_lvl] <= 1'b1;
		end else if (cpu.interrupt_return_op && any_in_svc && mc_end) begin
			isr_reg[cur_lvl] <= 1'b0;
		end
	end

	assign in_service = isr_reg;
	// plain_ret leaves isr_reg untouched, by design

	// ==========================================
	// power-down wake; service then returns to the next instruction
	// wake looks at the pins directly, not at the c3 samples
	logic ext_low;
	logic src_wake;
	assign ext_low = (!ext0_pin && cfg.ena[`ICW_SRC_EXT0])
		|| (!ext1_pin && cfg.ena[`ICW_SRC_EXT1]);
	assign src_wake = global_irq_enable && (ext_low
		|| (req[`ICW_SRC_BRN]) || (req[`ICW_SRC_WDT] && wdt_wake_ok)
		|| (req[`ICW_SRC_CMP] && cmp_wake_ok));

	icw_wake #(
		.TPD_CYCLES(TPD_CYCLES)
	) icw_wake_inst (
		.clk                    (clk),
		.rst_n_sync             (rst_n_sync),
		.pd_enter               (pd_enter),
		.pd_wake_mode           ({pd_wake_mode_sel_hi, pd_wake_mode_sel_lo}),
		.ext_low                (ext_low),
		.src_wake               (src_wake),
		.low_power_brownout_sel (low_power_brownout_sel),
		.brownout_detector_off  (brownout_detector_off),
		.power_down             (power_down),
		.osc_restart            (osc_restart),
		.rc_clk_en              (rc_clk_en)
	);
endmodule
`default_nettype wire

// File: verif/icw_ctrl_assertions.sv
`timescale 1ns/1ns
`default_nettype none
`include "icw_defs.svh"
module icw_ctrl_checker #(
	parameter int TPD_CYCLES = 20
) (
	// clock and reset
	input wire logic               clk,
	input wire logic               rstn,
	// configuration and cpu
	input wire logic               global_irq_enable,
	input wire icw_pkg::icw_cfg_t  cfg,
	input wire icw_pkg::icw_cpu_t  cpu,
	input wire icw_pkg::icw_vec9_t sw_flag_clr,
	input wire logic               low_power_brownout_sel,
	input wire logic               brownout_detector_off,
	// status
	input wire icw_pkg::icw_vec9_t flags,
	input wire icw_pkg::icw_call_t call,
	input wire logic               push_pc,
	input wire logic [3:0]         in_service,
	input wire logic               power_down,
	input wire logic               rc_clk_en,
	input wire logic [1:0]         state_phase
);
	import icw_pkg::*;
	logic [4:0] vcnt;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// ==========================================
	// helpers
	// count the cycles a vector call stands
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			vcnt <= 5'h00;
		else
			vcnt <= call.valid ? vcnt + 5'h01 : 5'h00;
	end
	// vector of each source index
	function automatic logic [15:0] vec(input logic [3:0] s);
		case (s)
			4'h0: vec = 16'h0003;
			4'h1: vec = 16'h002B;
			4'h2: vec = 16'h0053;
			4'h3: vec = 16'h000B;
			4'h4: vec = 16'h0013;
			4'h5: vec = 16'h001B;
			4'h6: vec = 16'h0023;
			4'h7: vec = 16'h0033;
			default: vec = 16'h006B;
		endcase
	endfunction
	// ==========================================
	// assertions
	a_push_gated: assert property (push_pc |-> global_irq_enable && !power_down)
		else $error("call taken while gated");
	a_push_slot: assert property (push_pc |-> state_phase == 2'h3 &&
		cpu.last_mc && !cpu.blocking && !cpu.interrupt_return_op)
		else $error("call taken outside its slot");
	a_push_call: assert property (push_pc |=> call.valid)
		else $error("push without vector call");
	a_call_len: assert property ($fell(call.valid) |-> vcnt == 5'h10)
		else $error("vector call length wrong");
	a_vec_map: assert property (call.valid |-> call.addr == vec(call.src))
		else $error("vector address wrong");
	a_level_map: assert property ($rose(call.valid) |->
		call.level == {cfg.pri_hi[call.src], cfg.pri_lo[call.src]})
		else $error("call level wrong");
	a_no_preempt: assert property ($rose(call.valid) |->
		($past(in_service) >> call.level) == 4'h0)
		else $error("pre-empted by equal or lower level");
	a_interrupt_return_op_clear: assert property (cpu.interrupt_return_op && state_phase == 2'h3 &&
		in_service != 4'h0 |=> (in_service ^ $past(in_service)) > in_service)
		else $error("return did not clear highest level");
	a_tmr_clear: assert property ($rose(call.valid) &&
		(call.src == 4'h3 || call.src == 4'h5) |-> !flags[call.src])
		else $error("timer flag not cleared on call");
	a_pwm_sticky: assert property ($fell(flags[8]) |-> $past(sw_flag_clr[8]))
		else $error("period flag cleared by hardware");
	a_rc_clock: assert property (rc_clk_en == (power_down &&
		low_power_brownout_sel && !brownout_detector_off))
		else $error("rc clock enable wrong");
	// ==========================================
	// covers
	c_call: cover property (push_pc);
	c_wake: cover property ($fell(power_down));
	c_top: cover property ($rose(call.valid) && call.level == 2'h3);
endmodule
bind icw_ctrl icw_ctrl_checker #(.TPD_CYCLES(TPD_CYCLES)) icw_ctrl_checker_inst (
	.clk, .rstn, .global_irq_enable, .cfg, .cpu, .sw_flag_clr,
	.low_power_brownout_sel, .brownout_detector_off, .flags, .call,
	.push_pc, .in_service, .power_down, .rc_clk_en, .state_phase);
`default_nettype wire

// File: verif/icw_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
module icw_cpu_model (
	// clock, reset and phase
	input wire logic       clk,
	input wire logic       rstn,
	input wire logic [1:0] state_phase,
	// bench controls
	input wire logic       do_interrupt_return_op,
	input wire logic       no_last,
	input wire logic       blk,
	// to the controller
	output var icw_pkg::icw_cpu_t cpu
);
	import icw_pkg::*;
	logic interrupt_return_op_reg;
	// return stands until one phase-3 edge has seen it
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			interrupt_return_op_reg <= 1'b0;
		else if (do_interrupt_return_op)
			interrupt_return_op_reg <= 1'b1;
		else if (state_phase == 2'h3)
			interrupt_return_op_reg <= 1'b0;
	end
	// instruction status seen by the controller
	assign cpu = '{last_mc: !no_last, blocking: blk, interrupt_return_op: interrupt_return_op_reg};
endmodule
`default_nettype wire

// File: verif/test_mcu_interrupt_and_wake_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module test_mcu_interrupt_and_wake_ctrl;
	import icw_pkg::*;
	// ==========================================
	// signals
	logic       clk, rstn, ext0_pin, ext1_pin, pd_enter, plain_ret;
	logic       ext0_trigger_type, ext1_trigger_type, sw_rx_clr, sw_tx_clr;
	logic [7:0] ev;
	icw_vec9_t  sw_flag_set, sw_flag_clr, flags;
	icw_cfg_t   cfg;
	icw_cpu_t   cpu;
	icw_call_t  call;
	logic       global_irq_enable, brownout_to_irq, do_interrupt_return_op, no_last, blk;
	logic       pd_wake_mode_sel_hi, pd_wake_mode_sel_lo, wok;
	logic       low_power_brownout_sel, brownout_detector_off;
	logic       receive_done_flag, transmit_done_flag, call_busy, push_pc;
	logic       power_down, osc_restart, rc_clk_en;
	logic [3:0] in_service;
	logic [1:0] state_phase;
	int         err_count, num_checks;
	// ==========================================
	// design and cpu model
	icw_ctrl #(.TPD_CYCLES(20)) icw_ctrl_inst (
		.clk, .rstn, .ext0_pin, .ext1_pin, .ext0_trigger_type,
		.ext1_trigger_type, .timer0_overflow(ev[0]), .timer1_overflow(ev[1]),
		.watchdog_timeout(ev[2]), .pwm_underflow(ev[3]),
		.comparator_event(ev[4]), .receive_done(ev[5]),
		.transmit_done(ev[6]), .brownout_event(ev[7]), .sw_flag_set,
		.sw_flag_clr, .sw_rx_clr, .sw_tx_clr, .global_irq_enable, .cfg,
		.brownout_to_irq, .pd_wake_mode_sel_hi, .pd_wake_mode_sel_lo,
		.low_power_brownout_sel, .brownout_detector_off,
		.wdt_wake_ok(wok), .cmp_wake_ok(wok), .cpu, .pd_enter,
		.plain_ret, .flags, .receive_done_flag, .transmit_done_flag, .call,
		.call_busy, .push_pc, .in_service, .power_down, .osc_restart,
		.rc_clk_en, .state_phase);
	icw_cpu_model icw_cpu_model_inst (.clk, .rstn, .state_phase, .do_interrupt_return_op,
		.no_last, .blk, .cpu);
	// clock
	always #50 clk = ~clk;
	// ==========================================
	// helpers
	task automatic chk(input string nm, input logic [15:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic summarize;
		if (err_count == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic clr_all;
		@(negedge clk) {sw_flag_clr, sw_rx_clr, sw_tx_clr} = 11'h7FF;
		@(negedge clk) {sw_flag_clr, sw_rx_clr, sw_tx_clr} = 11'h000;
	endtask
	task automatic set_flags(input icw_vec9_t b);
		@(negedge clk) sw_flag_set = b;
		@(negedge clk) sw_flag_set = 9'h000;
	endtask
	task automatic nocall(input string nm);
		cyc(40);
		chk(nm, {11'h0, in_service, call.valid}, 16'h0000);
	endtask
	// take one vector call, check it, then return from it
	task automatic serve(input logic [15:0] va, input icw_vec9_t fe,
		input logic [1:0] lv);
		int n;
		n = 0;
		while (call.valid !== 1'b1 && n < 200) begin
			@(negedge clk);
			n++;
		end
		chk("call", {15'h0, call.valid}, 16'h0001);
		chk("vector", call.addr, va);
		chk("flags", {7'h0, flags}, {7'h0, fe});
		chk("level", {14'h0, call.level}, {14'h0, lv});
		while (call_busy === 1'b1 && n < 300) begin
			@(negedge clk);
			n++;
		end
		plain_ret = 1'b1;
		@(negedge clk) plain_ret = 1'b0;
		cyc(4);
		chk("in service", {12'h0, in_service}, 16'h1 << lv);
		do_interrupt_return_op = 1'b1;
		@(negedge clk) do_interrupt_return_op = 1'b0;
		while (cpu.interrupt_return_op === 1'b1 && n < 400) begin
			@(negedge clk);
			n++;
		end
		chk("in service", {12'h0, in_service}, 16'h0000);
	endtask
	// ==========================================
	// scenarios
	// peripheral events set sticky flags, cleared here by software
	task automatic t_events;
		logic [15:0] s;
		logic [15:0] ex[8] = '{16'h0020, 16'h0080, 16'h0010, 16'h0400,
			16'h0200, 16'h0002, 16'h0001, 16'h0008};
		for (int i = 0; i < 8; i++) begin
			@(negedge clk);
			while (state_phase !== 2'h2) @(negedge clk);
			ev = 8'h01 << i;
			@(negedge clk) ev = 8'h00;
			cyc(8);
			s = {5'h00, flags, receive_done_flag, transmit_done_flag};
			chk("event flag", s, ex[i]);
			clr_all;
		end
	endtask
	// every source vectors to its own address
	task automatic t_vectors;
		icw_vec9_t b;
		logic [15:0] va[9] = '{16'h0003, 16'h002B, 16'h0053, 16'h000B,
			16'h0013, 16'h001B, 16'h0023, 16'h0033, 16'h006B};
		global_irq_enable = 1'b1;
		for (int i = 0; i < 9; i++) begin
			b = 9'h001 << i;
			set_flags(b);
			serve(va[i], (b & 9'h039) ? 9'h000 : b, 2'h0);
			clr_all;
		end
	endtask
	// equal levels by fixed order, a higher level goes first
	task automatic t_order;
		set_flags(9'h030);
		serve(16'h0013, 9'h020, 2'h0);
		serve(16'h001B, 9'h000, 2'h0);
		cfg.pri_hi = 9'h020;
		cfg.pri_lo = 9'h020;
		set_flags(9'h030);
		serve(16'h001B, 9'h010, 2'h3);
		serve(16'h0013, 9'h000, 2'h0);
		cfg.pri_hi = 9'h000;
		cfg.pri_lo = 9'h000;
	endtask
	// no call while gated, and a dropped request is forgotten
	task automatic t_gate;
		global_irq_enable = 1'b0;
		set_flags(9'h008);
		nocall("global off");
		global_irq_enable = 1'b1;
		cfg.ena = 9'h1F7;
		nocall("enable off");
		cfg.ena = 9'h1FF;
		blk = 1'b1;
		nocall("blocking");
		blk = 1'b0;
		no_last = 1'b1;
		nocall("not last");
		clr_all;
		no_last = 1'b0;
		nocall("dropped");
	endtask
	// edge mode latches a fall, level mode follows the pin
	task automatic t_pins;
		global_irq_enable = 1'b0;
		ext0_pin = 1'b0;
		cyc(8);
		chk("edge flag", {7'h0, flags}, 16'h0001);
		ext0_pin = 1'b1;
		ext1_trigger_type = 1'b0;
		ext1_pin = 1'b0;
		cyc(8);
		chk("level flag", {7'h0, flags}, 16'h0011);
		ext1_pin = 1'b1;
		cyc(8);
		chk("level flag", {7'h0, flags}, 16'h0001);
		ext1_trigger_type = 1'b1;
		clr_all;
	endtask
	// power-down ends only through an enabled wake source
	task automatic t_wake;
		int n;
		logic o;
		pd_enter = 1'b1;
		@(negedge clk) pd_enter = 1'b0;
		ext0_pin = 1'b0;
		cyc(12);
		chk("pd held", {15'h0, power_down}, 16'h0001);
		chk("rc clock", {15'h0, rc_clk_en}, 16'h0001);
		brownout_detector_off = 1'b1;
		@(negedge clk) chk("rc clock", {15'h0, rc_clk_en}, 16'h0000);
		brownout_detector_off = 1'b0;
		ext0_pin = 1'b1;
		clr_all;
		global_irq_enable = 1'b1;
		for (int m = 0; m < 4; m++) begin
			{pd_wake_mode_sel_hi, pd_wake_mode_sel_lo} = 2'(m);
			cyc(8);
			ext0_pin = 1'b0;
			n = 0;
			o = 1'b0;
			while (power_down === 1'b1 && n < 60) begin
				@(negedge clk);
				o = o | osc_restart;
				n++;
			end
			chk("wake", {14'h0, power_down, o}, 16'h0001);
			chk("hold", {15'h0, n >= 20}, {15'h0, m == 1 || m == 2});
			serve(16'h0003, 9'h000, 2'h0);
			ext0_pin = 1'b1;
			cyc(8);
			pd_enter = 1'b1;
			@(negedge clk) pd_enter = 1'b0;
		end
		set_flags(9'h004);
		nocall("wdt gated");
		chk("pd kept", {15'h0, power_down}, 16'h0001);
		wok = 1'b1;
		serve(16'h0053, 9'h004, 2'h0);
		clr_all;
	endtask
	// ==========================================
	// main sequence and watchdog
	initial begin
		{clk, rstn, ev, pd_enter, plain_ret, do_interrupt_return_op, wok} = '0;
		{ext0_pin, ext1_pin, ext0_trigger_type, ext1_trigger_type} = 4'hF;
		{sw_flag_set, sw_flag_clr, sw_rx_clr, sw_tx_clr} = '0;
		{global_irq_enable, no_last, blk, brownout_to_irq} = 4'h1;
		{pd_wake_mode_sel_hi, pd_wake_mode_sel_lo} = 2'h0;
		{low_power_brownout_sel, brownout_detector_off} = 2'h2;
		cfg = '{ena: 9'h1FF, pri_hi: 9'h000, pri_lo: 9'h000};
		err_count = 0;
		num_checks = 0;
		repeat (2) @(posedge clk);
		@(negedge clk) rstn = 1'b1;
		cyc(4);
		chk("reset flags", {7'h0, flags}, 16'h0000);
		chk("reset call", {15'h0, call.valid}, 16'h0000);
		t_events;
		t_vectors;
		t_order;
		t_gate;
		t_pins;
		t_wake;
		summarize;
	end
	initial begin
		#3000000;
		err_count++;
		summarize;
	end
endmodule
`default_nettype wire
